// File: logic/usb_bulk_out_dual_fifo.sv
// Pull-up control, control-stage tracking and bulk-out ping-pong buffers
`include "usb_bulk_params.svh"
module usb_bulk_out_dual_fifo (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dplus_bias_enable,
    output logic dplus_bias_control_pin,
    input wire logic setup_token,
    input wire logic ctrl_data_txn,
    input wire logic ctrl_status_txn,
    output usb_bulk_pkg::ctrl_stage_t ctrl_stage,
    input wire logic rx_start,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_done,
    input wire logic rx_error,
    output logic rx_nak,
    input wire logic rd_strobe,
    output logic [7:0] rd_data,
    output logic [`CNT_W-1:0] rd_count,
    output logic bulk_out_buffer_full_flag,
    input wire logic flag_clear,
    input wire logic bulk_out_read_done_trigger,
    output logic xfer_request
);
    import usb_bulk_pkg::*;
    logic bias_q;
    ctrl_stage_t stage_q;
    logic wsel_q, rsel_q, active_q, flag_q, req_q;
    logic [1:0] full_w;
    logic [`CNT_W-1:0] cnt_w [0:1];
    logic [7:0] data_w [0:1];
    logic both_full, wr_full, commit_ev, release_ev;

    assign both_full = full_w[0] & full_w[1];
    assign wr_full = full_w[wsel_q];
    assign commit_ev = active_q & rx_done & ~rx_error;
    assign release_ev = bulk_out_read_done_trigger & full_w[rsel_q];

    // Pull-up output from the bias enable bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bias_q <= 1'b0;
        end else begin
            bias_q <= dplus_bias_enable;
        end
    end
    assign dplus_bias_control_pin = bias_q;

    // Control transfer stage sequence
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage_q <= CTRL_IDLE;
        end else if (setup_token) begin
            stage_q <= CTRL_SETUP;
        end else begin
            case (stage_q)
                CTRL_SETUP: begin
                    if (ctrl_data_txn) begin
                        stage_q <= CTRL_DATA;
                    end else if (ctrl_status_txn) begin
                        stage_q <= CTRL_STATUS;
                    end
                end
                CTRL_DATA: begin
                    if (ctrl_status_txn) begin
                        stage_q <= CTRL_STATUS;
                    end
                end
                CTRL_STATUS: stage_q <= CTRL_IDLE;
                default: stage_q <= CTRL_IDLE;
            endcase
        end
    end
    assign ctrl_stage = stage_q;

    // Packet in progress; refused packets never become active
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
        end else if (rx_start) begin
            active_q <= ~wr_full;
        end else if (rx_done || rx_error) begin
            active_q <= 1'b0;
        end
    end

    assign rx_nak = rx_start & wr_full;

    // Write side alternates after each completed packet
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wsel_q <= 1'b0;
        end else if (commit_ev) begin
            wsel_q <= ~wsel_q;
        end
    end

    // Read side alternates on each release
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rsel_q <= 1'b0;
        end else if (release_ev) begin
            rsel_q <= ~rsel_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_buf
            bulk_rx_buffer u_buf (
                .ref_clk(ref_clk),
                .rst(rst),
                .wr_en(active_q & rx_valid & (wsel_q == 1'(g))),
                .wr_data(rx_data),
                .commit(commit_ev & (wsel_q == 1'(g))),
                .abort(active_q & rx_error & (wsel_q == 1'(g))),
                .rd_en(rd_strobe & (rsel_q == 1'(g))),
                .release_buf(release_ev & (rsel_q == 1'(g))),
                .full(full_w[g]),
                .count(cnt_w[g]),
                .rd_data(data_w[g])
            );
        end
    endgenerate

    assign rd_data = data_w[rsel_q];
    assign rd_count = cnt_w[rsel_q];

    // Full flag: a hardware set wins over a software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (commit_ev) begin
            flag_q <= 1'b1;
        end else if (release_ev && full_w[~rsel_q]) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end
    assign bulk_out_buffer_full_flag = flag_q;

    // One byte request per read slot for block moves
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req_q <= 1'b0;
        end else begin
            req_q <= full_w[rsel_q] & ~release_ev & ~rd_strobe;
        end
    end
    assign xfer_request = req_q;
endmodule // usb_bulk_out_dual_fifo

// File: logic/usb_bulk_params.svh
// Constants for the bulk-out dual buffer block
`ifndef USB_BULK_PARAMS_SVH
`define USB_BULK_PARAMS_SVH
`define BUF_BYTES 64
`define BUF_AW 6
`define CNT_W 7
`endif

// File: logic/usb_bulk_pkg.sv
// Types for the bulk-out dual buffer block
package usb_bulk_pkg;
    typedef enum logic [1:0] {
        CTRL_IDLE,
        CTRL_SETUP,
        CTRL_DATA,
        CTRL_STATUS
    } ctrl_stage_t;
    typedef logic [7:0] byte_t;
endpackage

// File: logic/bulk_rx_buffer.sv
// One 64-byte receive buffer with write and read pointers
`include "usb_bulk_params.svh"
module bulk_rx_buffer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic commit,
    input wire logic abort,
    input wire logic rd_en,
    input wire logic release_buf,
    output logic full,
    output logic [`CNT_W-1:0] count,
    output logic [7:0] rd_data
);
    import usb_bulk_pkg::*;
    byte_t mem [0:`BUF_BYTES-1];
    logic [`CNT_W-1:0] wptr_q;
    logic [`BUF_AW-1:0] rptr_q;
    logic full_q;

    always_ff @(posedge ref_clk) begin
        if (wr_en && !full_q && wptr_q < `CNT_W'(`BUF_BYTES)) begin
            mem[wptr_q[`BUF_AW-1:0]] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wptr_q <= '0;
            full_q <= 1'b0;
        end else if (release_buf) begin
            wptr_q <= '0;
            full_q <= 1'b0;
        end else if (abort && !full_q) begin
            wptr_q <= '0;
        end else if (commit && !full_q) begin
            full_q <= 1'b1;
        end else if (wr_en && !full_q && wptr_q < `CNT_W'(`BUF_BYTES)) begin
            wptr_q <= wptr_q + `CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rptr_q <= '0;
            rd_data <= 8'h00;
        end else if (release_buf) begin
            rptr_q <= '0;
        end else if (rd_en && full_q) begin
            rd_data <= mem[rptr_q];
            rptr_q <= rptr_q + `BUF_AW'(1);
        end
    end

    assign full = full_q;
    assign count = wptr_q;
endmodule // bulk_rx_buffer

// File: test/usb_bulk_out_dual_fifo_properties.sv
// Port checks for the bulk-out block
module usb_bulk_out_dual_fifo_properties (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dplus_bias_enable,
    input wire logic dplus_bias_control_pin,
    input wire logic setup_token,
    input wire usb_bulk_pkg::ctrl_stage_t ctrl_stage,
    input wire logic rx_start,
    input wire logic rx_nak,
    input wire logic rx_done,
    input wire logic bulk_out_buffer_full_flag,
    input wire logic flag_clear,
    input wire logic bulk_out_read_done_trigger,
    input wire logic xfer_request
);
    timeunit 1ns;
    timeprecision 1ps;
    import usb_bulk_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_off; !dplus_bias_enable |=> !dplus_bias_control_pin; endproperty
    a_off: assert property (p_off) else $error("pin high");
    property p_on; dplus_bias_enable |=> dplus_bias_control_pin; endproperty
    a_on: assert property (p_on) else $error("pin low");
    property p_setup; setup_token |=> ctrl_stage == CTRL_SETUP; endproperty
    a_setup: assert property (p_setup) else $error("no setup");
    property p_end; ctrl_stage == CTRL_STATUS && !setup_token |=> ctrl_stage == CTRL_IDLE; endproperty
    a_end: assert property (p_end) else $error("no idle");
    property p_nak; rx_nak |-> rx_start; endproperty
    a_nak: assert property (p_nak) else $error("stray nak");
    property p_full; rx_done |=> bulk_out_buffer_full_flag ##1 xfer_request; endproperty
    a_full: assert property (p_full) else $error("no flag");
    property p_hold; bulk_out_buffer_full_flag && !flag_clear |=> bulk_out_buffer_full_flag; endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_rise; $rose(bulk_out_buffer_full_flag) |-> $past(rx_done) || $past(bulk_out_read_done_trigger); endproperty
    a_rise: assert property (p_rise) else $error("flag cause");
endmodule // usb_bulk_out_dual_fifo_properties
bind usb_bulk_out_dual_fifo usb_bulk_out_dual_fifo_properties chk_u (.*);

// File: test/usb_host_model.sv
// Host side that sends bulk-out packets
module usb_host_model (
    input wire logic ref_clk,
    input wire logic rx_nak,
    output logic rx_start,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_done,
    output logic rx_error
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rx_start, rx_valid, rx_data, rx_done, rx_error} = 0;
    task automatic send(input int n, input logic [7:0] b0, input bit ab, output logic nak);
        @(negedge ref_clk) rx_start = 1;
        #1 nak = rx_nak;
        @(negedge ref_clk) rx_start = 0;
        if (nak) return;
        for (int i = 0; i < n; i++) begin
            rx_valid = 1;
            rx_data = b0 + 8'(i);
            @(negedge ref_clk);
        end
        rx_valid = 0;
        rx_data = ~rx_data;
        {rx_done, rx_error} = {!ab, ab};
        @(negedge ref_clk) {rx_done, rx_error} = 0;
    endtask
endmodule // usb_host_model

// File: test/tb.sv
// Self-checking bench for the bulk-out block
`include "usb_bulk_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import usb_bulk_pkg::*;
    logic ref_clk = 0, rst = 1, dplus_bias_enable = 0, setup_token = 0, ctrl_data_txn = 0;
    logic ctrl_status_txn = 0, rd_strobe = 0, flag_clear = 0, bulk_out_read_done_trigger = 0;
    logic rx_start, rx_valid, rx_done, rx_error, rx_nak, dplus_bias_control_pin, nak;
    logic bulk_out_buffer_full_flag, xfer_request;
    logic [7:0] rx_data, rd_data;
    logic [`CNT_W-1:0] rd_count;
    ctrl_stage_t ctrl_stage;
    int fail_count = 0, tests_run = 0, cyc = 0;
    // Length, first byte, bias, stored count
    logic [7:0] rows[3][4] = '{'{1, 8'h10, 1, 1}, '{64, 8'hc0, 0, 64}, '{70, 8'h80, 1, 64}};
    usb_bulk_out_dual_fifo dut_u (.*);
    usb_host_model host_u (.*);
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (++cyc == 20000) begin
        fail_count++;
        final_report();
    end
    task automatic final_report();
        $display("checks %0d failures %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1;
        @(negedge ref_clk) s = 0;
    endtask
    task automatic drain(int n, logic [7:0] b0);
        for (int i = 0; i < n; i++) begin
            pulse(rd_strobe);
            chk(rd_data, b0 + 8'(i));
        end
        @(negedge ref_clk) {bulk_out_read_done_trigger, flag_clear} = 2'b11;
        @(negedge ref_clk) {bulk_out_read_done_trigger, flag_clear} = 2'b00;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 0;
        chk(ctrl_stage, CTRL_IDLE);
        foreach (rows[i]) begin
            dplus_bias_enable = rows[i][2];
            host_u.send(rows[i][0], rows[i][1], 0, nak);
            chk(dplus_bias_control_pin, rows[i][2]);
            chk(bulk_out_buffer_full_flag, 1);
            chk(rd_count, rows[i][3]);
            drain(rows[i][3], rows[i][1]);
            chk(bulk_out_buffer_full_flag, 0);
            $display("row %0d done", i);
        end
        host_u.send(4, 8'h20, 0, nak);
        host_u.send(4, 8'h30, 0, nak);
        chk(nak, 0);
        host_u.send(4, 8'h40, 0, nak);
        chk(nak, 1);
        drain(4, 8'h20);
        chk(bulk_out_buffer_full_flag, 1);
        drain(4, 8'h30);
        chk(bulk_out_buffer_full_flag, 0);
        host_u.send(5, 8'h50, 1, nak);
        chk(bulk_out_buffer_full_flag, 0);
        $display("ping-pong done");
        pulse(setup_token);
        chk(ctrl_stage, CTRL_SETUP);
        pulse(ctrl_data_txn);
        chk(ctrl_stage, CTRL_DATA);
        pulse(ctrl_status_txn);
        chk(ctrl_stage, CTRL_STATUS);
        @(negedge ref_clk);
        chk(ctrl_stage, CTRL_IDLE);
        $display("control done");
        final_report();
    end
endmodule // tb
